// ==== hdl/capture_seq_pkg.sv ====
/*
 * Shared constants for the multi-trigger capture handshake sequencer.
 * Assumes a single 10 MHz system clock; no other domain is involved.
 */
package capture_seq_pkg;

    // ========================================================
    // Clock and timing
    // ========================================================
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned SEC_IN_NS       = 1_000_000_000;
    localparam int unsigned CYCLES_PER_SEC  = SEC_IN_NS / CLK_PERIOD_NS;

    // ========================================================
    // Wait limit between triggers, in seconds
    // ========================================================
    localparam int unsigned SEC_W           = 6;
    localparam logic [5:0]  TIMEOUT_MIN_SEC = 6'h01;
    localparam logic [5:0]  TIMEOUT_MAX_SEC = 6'h3c;
    localparam logic [5:0]  TIMEOUT_DEF_SEC = 6'h0a;

    // ========================================================
    // Sequence sizing
    // ========================================================
    localparam int unsigned TASK_W          = 4;

    // ========================================================
    // Sequencer states
    // ========================================================
    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_SETUP   = 7'h02,
        ST_CAPTURE = 7'h04,
        ST_HOLD    = 7'h08,
        ST_ARMED   = 7'h10,
        ST_DRAIN   = 7'h20,
        ST_CALC    = 7'h40
    } seq_state_t;

endpackage

// ==== hdl/wait_timer.sv ====
/*
 * Wait timer: counts whole seconds while run_in is high and pulses
 * expired_out once the configured limit is reached.
 * Assumes limit_sec_in is stable while running; run_in low restarts it.
 */
`timescale 1ns/1ps

module wait_timer #(
    parameter int unsigned CYCLES_PER_SEC = capture_seq_pkg::CYCLES_PER_SEC
) (
    input  wire logic                              core_clk_in,
    input  wire logic                              nrst_in,
    input  wire logic                              run_in,
    input  wire logic [capture_seq_pkg::SEC_W-1:0] limit_sec_in,
    output logic                                   expired_out
);
    import capture_seq_pkg::*;

    localparam logic [31:0] TICK_LAST = 32'(CYCLES_PER_SEC - 1);

    typedef struct packed {
        logic [31:0]      tick;
        logic [SEC_W-1:0] secs;
        logic             expired;
        logic             done;
    } timer_state_t;

    timer_state_t cur;
    timer_state_t next_cur;
    logic [SEC_W-1:0] limit;

    // Out-of-range settings are clamped rather than rejected
    always_comb begin
        if (limit_sec_in < TIMEOUT_MIN_SEC) begin
            limit = TIMEOUT_MIN_SEC;
        end else if (limit_sec_in > TIMEOUT_MAX_SEC) begin
            limit = TIMEOUT_MAX_SEC;
        end else begin
            limit = limit_sec_in;
        end
    end

    always_comb begin
        next_cur         = cur;
        next_cur.expired = 1'b0;
        if (!run_in) begin
            next_cur.tick = 32'h0;
            next_cur.secs = '0;
            next_cur.done = 1'b0;
        end else if (!cur.done) begin
            if (cur.tick == TICK_LAST) begin
                next_cur.tick = 32'h0;
                next_cur.secs = cur.secs + 1'b1;
                if (cur.secs + 1'b1 == limit) begin
                    next_cur.expired = 1'b1;
                    next_cur.done    = 1'b1;
                end
            end else begin
                next_cur.tick = cur.tick + 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign expired_out = cur.expired;

endmodule // wait_timer

// ==== hdl/capture_seq.sv ====
/*
 * Multi-trigger capture handshake sequencer: trigger, ready and busy
 * toward the controller; start/done pulses toward the camera setup,
 * capture, measurement and final calculation engines.
 * Assumes all inputs are synchronous to core_clk_in and that each
 * engine answers every start pulse with exactly one done pulse.
 */
// What this block does
// - First trigger drops ready, raises busy and starts the first capture (shared) or camera setup.
// - Shared settings: ready returns when capture ends; measurement runs behind.
// - Later triggers come only with ready high; ready drops, busy stays.
// - No parallel measurement: measurements run one at a time, in order.
// - After all measurement and final calculation, busy drops, display starts.
// - Individual settings: each capture first applies its own camera setup.
// - Individual plus parallel: ready returns right after the first capture.
// - Individual plus parallel: later captures hold ready low until measured.
// - Final calculation starts only after every started task has completed.
// - Individual plus parallel: at the end ready is high, busy low.
// - Both options off: measure straight after capture, ready low meanwhile.
// - Both options off: ready returns only when that measurement completes.
// - No trigger within the wait limit after ready marks judgment failed.
// - A trigger while ready is low is refused and raises the error output.
`timescale 1ns/1ps

module capture_seq #(
    parameter int unsigned TASK_W         = capture_seq_pkg::TASK_W,
    parameter int unsigned CYCLES_PER_SEC = capture_seq_pkg::CYCLES_PER_SEC
) (
    input  wire logic                              core_clk_in,
    input  wire logic                              nrst_in,
    input  wire logic                              trigger_in,
    input  wire logic                              shared_settings_in,
    input  wire logic                              parallel_meas_in,
    input  wire logic [TASK_W-1:0]                 task_count_in,
    input  wire logic [capture_seq_pkg::SEC_W-1:0] timeout_sec_in,
    input  wire logic                              setup_done_in,
    input  wire logic                              capture_done_in,
    input  wire logic                              meas_done_in,
    input  wire logic                              calc_done_in,
    output logic                                   ready_out,
    output logic                                   busy_out,
    output logic                                   error_out,
    output logic                                   judge_ng_out,
    output logic                                   setup_start_out,
    output logic                                   capture_start_out,
    output logic                                   meas_start_out,
    output logic                                   calc_start_out,
    output logic                                   display_start_out
);
    import capture_seq_pkg::*;

    // ========================================================
    // State
    // ========================================================
    typedef struct packed {
        seq_state_t      st;
        logic            trig_q;
        logic            ready;
        logic            busy;
        logic            error;
        logic            judge_ng;
        logic            setup_go;
        logic            cap_go;
        logic            meas_go;
        logic            calc_go;
        logic            disp_go;
        logic            shared;
        logic            par;
        logic [TASK_W-1:0] total;
        logic [TASK_W-1:0] idx;
        logic [TASK_W-1:0] pend;
        logic [TASK_W-1:0] outst;
    } seq_regs_t;

    seq_regs_t cur;
    seq_regs_t next_cur;
    logic      trig_rise;
    logic      timed_out;
    logic      meas_idle;
    logic      issue;

    // Wait limit only runs while armed for a later trigger
    wait_timer #(
        .CYCLES_PER_SEC (CYCLES_PER_SEC)
    ) u_wait_timer (
        .core_clk_in    (core_clk_in),
        .nrst_in        (nrst_in),
        .run_in         (cur.st == ST_ARMED),
        .limit_sec_in   (timeout_sec_in),
        .expired_out    (timed_out)
    );

    assign trig_rise = trigger_in && !cur.trig_q;
    assign meas_idle = (cur.pend == '0) && (cur.outst == '0);

    // Start the oldest waiting measurement; serial unless parallel
    always_comb begin
        issue = (cur.pend != '0) && (cur.par || (cur.outst == '0));
    end

    // ========================================================
    // Next-state logic
    // ========================================================
    always_comb begin
        next_cur          = cur;
        next_cur.trig_q   = trigger_in;
        next_cur.setup_go = 1'b0;
        next_cur.cap_go   = 1'b0;
        next_cur.meas_go  = issue;
        next_cur.calc_go  = 1'b0;
        next_cur.disp_go  = 1'b0;

        // Measurement bookkeeping runs beside the handshake
        next_cur.pend  = cur.pend
                       + TASK_W'(cur.st == ST_CAPTURE && capture_done_in)
                       - TASK_W'(issue);
        next_cur.outst = cur.outst + TASK_W'(issue)
                       - TASK_W'(meas_done_in && cur.outst != '0);

        // Refused trigger; cleared by the next accepted one
        if (trig_rise && !cur.ready) begin
            next_cur.error = 1'b1;
        end

        case (cur.st)
            ST_IDLE: begin
                if (trig_rise) begin
                    // Options are frozen for the whole sequence
                    next_cur.shared   = shared_settings_in;
                    next_cur.par      = parallel_meas_in;
                    next_cur.total    = (task_count_in == '0) ?
                                        TASK_W'(1) : task_count_in;
                    next_cur.idx      = '0;
                    next_cur.judge_ng = 1'b0;
                    next_cur.error    = 1'b0;
                    next_cur.ready    = 1'b0;
                    next_cur.busy     = 1'b1;
                    if (shared_settings_in) begin
                        next_cur.st     = ST_CAPTURE;
                        next_cur.cap_go = 1'b1;
                    end else begin
                        next_cur.st       = ST_SETUP;
                        next_cur.setup_go = 1'b1;
                    end
                end
            end
            ST_SETUP: begin
                if (setup_done_in) begin
                    next_cur.st     = ST_CAPTURE;
                    next_cur.cap_go = 1'b1;
                end
            end
            ST_CAPTURE: begin
                if (capture_done_in) begin
                    next_cur.idx = cur.idx + 1'b1;
                    if (cur.idx + 1'b1 == cur.total) begin
                        next_cur.st = ST_DRAIN;
                    end else if (cur.shared ||
                                 (cur.par && cur.idx == '0)) begin
                        next_cur.st    = ST_ARMED;
                        next_cur.ready = 1'b1;
                    end else begin
                        next_cur.st = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                // The capture just taken has been measured
                if (meas_idle) begin
                    next_cur.st    = ST_ARMED;
                    next_cur.ready = 1'b1;
                end
            end
            ST_ARMED: begin
                if (trig_rise) begin
                    next_cur.ready = 1'b0;
                    next_cur.error = 1'b0;
                    if (cur.shared) begin
                        next_cur.st     = ST_CAPTURE;
                        next_cur.cap_go = 1'b1;
                    end else begin
                        next_cur.st       = ST_SETUP;
                        next_cur.setup_go = 1'b1;
                    end
                end else if (timed_out) begin
                    // Remaining captures are abandoned
                    next_cur.judge_ng = 1'b1;
                    next_cur.ready    = 1'b0;
                    next_cur.st       = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (meas_idle && !issue) begin
                    next_cur.st      = ST_CALC;
                    next_cur.calc_go = 1'b1;
                end
            end
            ST_CALC: begin
                if (calc_done_in) begin
                    next_cur.st      = ST_IDLE;
                    next_cur.busy    = 1'b0;
                    next_cur.ready   = 1'b1;
                    next_cur.disp_go = 1'b1;
                end
            end
            default: begin
                next_cur.st    = ST_IDLE;
                next_cur.ready = 1'b1;
                next_cur.busy  = 1'b0;
            end
        endcase
    end

    // ========================================================
    // Registers
    // ========================================================
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cur       <= '0;
            cur.st    <= ST_IDLE;
            cur.ready <= 1'b1;
            // Held high so a trigger level present at reset is no edge
            cur.trig_q <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // ========================================================
    // Outputs
    // ========================================================
    assign ready_out         = cur.ready;
    assign busy_out          = cur.busy;
    assign error_out         = cur.error;
    assign judge_ng_out      = cur.judge_ng;
    assign setup_start_out   = cur.setup_go;
    assign capture_start_out = cur.cap_go;
    assign meas_start_out    = cur.meas_go;
    assign calc_start_out    = cur.calc_go;
    assign display_start_out = cur.disp_go;

endmodule // capture_seq

// ==== verification/capture_seq_monitor.sv ====
/* Port checker for capture_seq, bound from the bench top file.
   Assumes option inputs and task count stay put during a sequence. */
`timescale 1ns/1ps
module capture_seq_monitor #(
    parameter int unsigned TASK_W = 4
) (
    input wire logic              core_clk_in,
    input wire logic              nrst_in,
    input wire logic              trigger_in,
    input wire logic              shared_settings_in,
    input wire logic              parallel_meas_in,
    input wire logic [TASK_W-1:0] task_count_in,
    input wire logic              capture_done_in,
    input wire logic              meas_done_in,
    input wire logic              calc_done_in,
    input wire logic              ready_out,
    input wire logic              busy_out,
    input wire logic              error_out,
    input wire logic              judge_ng_out,
    input wire logic              setup_start_out,
    input wire logic              capture_start_out,
    input wire logic              meas_start_out,
    input wire logic              calc_start_out,
    input wire logic              display_start_out
);
    // ========================================================
    // Helper counts: measurements in flight, captures so far
    // ========================================================
    logic [7:0]    outst;
    logic [TASK_W:0] caps;
    logic          last_cap;
    assign last_cap = (caps + 1'b1) >= {1'b0, task_count_in};
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            outst <= 8'h00;
            caps  <= '0;
        end else begin
            outst <= outst + 8'(meas_start_out)
                     - 8'(meas_done_in && outst != 8'h00);
            if (!busy_out) caps <= '0;
            else if (capture_done_in) caps <= caps + 1'b1;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    // ========================================================
    // Assertions
    // ========================================================
    a_first_trigger: assert property (
        ready_out && !busy_out && $rose(trigger_in) |=> !ready_out && busy_out)
        else $error("first trigger not taken");
    a_later_trigger: assert property (
        ready_out && busy_out && $rose(trigger_in) |=> !ready_out && busy_out)
        else $error("later trigger not taken");
    a_refused_trigger: assert property (
        !ready_out && $rose(trigger_in) |=> error_out)
        else $error("refused trigger gave no error");
    a_start_kind: assert property (
        ready_out && $rose(trigger_in) |=> shared_settings_in ?
        capture_start_out && !setup_start_out :
        setup_start_out && !capture_start_out)
        else $error("wrong start after trigger");
    a_shared_ready: assert property (
        busy_out && shared_settings_in && capture_done_in && !last_cap
        |=> ready_out) else $error("ready not back after capture");
    a_first_par_ready: assert property (
        busy_out && !shared_settings_in && parallel_meas_in && caps == '0
        && capture_done_in && !last_cap |=> ready_out)
        else $error("ready not back after first capture");
    a_both_off_hold: assert property (
        !shared_settings_in && !parallel_meas_in && capture_done_in
        |=> !ready_out) else $error("ready back before measurement");
    a_serial_single: assert property (
        !parallel_meas_in && outst != 8'h00 |-> !meas_start_out)
        else $error("second measurement started early");
    a_calc_after_all: assert property (
        calc_start_out |-> outst == 8'h00 && !ready_out)
        else $error("calculation started early");
    a_finish_idle: assert property (
        busy_out && calc_done_in |=> !busy_out && ready_out
        && display_start_out) else $error("sequence end wrong");
    a_judge_fail: assert property (
        $rose(judge_ng_out) |-> !ready_out && $past(ready_out))
        else $error("judgment failed outside wait");
    c_display: cover property (display_start_out);
    c_error: cover property ($rose(error_out));
    c_overlap: cover property (outst > 8'h01);
endmodule // capture_seq_monitor

// ==== verification/far_side_model.sv ====
/* Far side: engines answer each start with one done pulse lat_in
   cycles later; the controller runs the trigger handshake.
   Assumes stimulus moves on falling clock edges. */
`timescale 1ns/1ps
module engine_model (
    input  wire logic       clk_in,
    input  wire logic       start_in,
    input  wire logic [3:0] lat_in,
    output logic            done_out
);
    int q[$];
    int now = 0;
    initial done_out = 1'b0;
    always @(posedge clk_in) if (start_in) q.push_back(now + lat_in);
    always @(negedge clk_in) begin
        now++;
        done_out <= 1'b0;
        if (q.size() > 0 && q[0] <= now) begin
            done_out <= 1'b1;
            void'(q.pop_front());
        end
    end
endmodule // engine_model

module plc_model (
    input  wire logic clk_in,
    input  wire logic ready_in,
    input  wire logic busy_in,
    output logic      trigger_out
);
    initial trigger_out = 1'b0;
    task automatic step(input bit first);
        @(negedge clk_in);
        while (!ready_in || (first && busy_in)) @(negedge clk_in);
        trigger_out <= 1'b1;
        do @(negedge clk_in);
        while (ready_in || (first && !busy_in));
        trigger_out <= 1'b0;
        @(negedge clk_in);
    endtask
    // Deliberately ignores ready, only for the refusal case
    task automatic stray();
        @(negedge clk_in);
        trigger_out <= 1'b1;
        @(negedge clk_in);
        trigger_out <= 1'b0;
        @(negedge clk_in);
    endtask
endmodule // plc_model

// ==== verification/capture_seq_test.sv ====
/* Self-checking bench for capture_seq with far-side models.
   Assumes a 20-cycle second so the wait limit stays short. */
`timescale 1ns/1ps
module capture_seq_test;
    import capture_seq_pkg::*;
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic shared_settings_in, parallel_meas_in, trigger_in, ready_out;
    logic setup_done_in, capture_done_in, meas_done_in, calc_done_in;
    logic busy_out, error_out, judge_ng_out, setup_start_out;
    logic capture_start_out, meas_start_out, calc_start_out;
    logic display_start_out;
    logic [3:0] task_count_in, lat;
    logic [SEC_W-1:0] timeout_sec_in;
    integer seed = 39184;
    int errors = 0, checks_done = 0, cyc = 0;
    int caps, meas_d, setups, disp, last_md, calc_at;
    // Short simulated second keeps the wait limit within a few hundred cycles
    localparam int SIM_SEC = 20;
    // Reference model: captured images waiting for their measurement
    int pend_q[$];
    int in_flight = 0;
    always #50 core_clk_in = ~core_clk_in;
    capture_seq #(.CYCLES_PER_SEC(SIM_SEC)) i_capture_seq (.*);
    plc_model u_plc (.clk_in(core_clk_in), .ready_in(ready_out),
        .busy_in(busy_out), .trigger_out(trigger_in));
    engine_model u_set (.clk_in(core_clk_in), .start_in(setup_start_out),
        .lat_in(lat), .done_out(setup_done_in));
    engine_model u_cap (.clk_in(core_clk_in), .start_in(capture_start_out),
        .lat_in(lat), .done_out(capture_done_in));
    engine_model u_mea (.clk_in(core_clk_in), .start_in(meas_start_out),
        .lat_in(lat), .done_out(meas_done_in));
    engine_model u_cal (.clk_in(core_clk_in), .start_in(calc_start_out),
        .lat_in(lat), .done_out(calc_done_in));
    // ========================================================
    // Reference counts
    // ========================================================
    always @(posedge core_clk_in) begin
        cyc++;
        caps += int'(capture_done_in);
        meas_d += int'(meas_done_in);
        setups += int'(setup_start_out);
        disp += int'(display_start_out);
        if (meas_done_in) last_md = cyc;
        if (calc_start_out) calc_at = cyc;
        // Every measurement needs a captured image; serial allows one at a time
        if (meas_start_out) begin
            check("meas source", 8'(pend_q.size() > 0), 8'h01);
            check("serial", 8'(in_flight == 0 || parallel_meas_in), 8'h01);
            if (pend_q.size() > 0) void'(pend_q.pop_front());
        end
        in_flight += int'(meas_start_out)
                     - int'(meas_done_in && in_flight > 0);
        if (capture_done_in) pend_q.push_back(caps);
    end
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Mode 1 leaves out the second trigger, mode 2 adds a stray one
    task automatic run_seq(input bit s, input bit p, input int n,
                           input int mode);
        int eff;
        bit exp_rdy;
        int waited;
        bit in_win;
        @(negedge core_clk_in);
        eff = (n == 0) ? 1 : n;
        shared_settings_in = s;
        parallel_meas_in = p;
        task_count_in = 4'(n);
        timeout_sec_in = (mode == 1) ? 6'h01 : 6'(10 + ($random(seed) & 31));
        lat = 4'(3 + ($random(seed) & 7));
        {caps, meas_d, setups, disp} = '0;
        for (int i = 0; i < eff && !(mode == 1 && i == 1); i++) begin
            u_plc.step(i == 0);
            check("busy", busy_out, 1);
            check("error", error_out, 0);
            if (mode == 2) begin
                u_plc.stray();
                check("stray error", error_out, 1);
            end
            for (int k = 0; k < 500 && caps <= i; k++) @(negedge core_clk_in);
            @(negedge core_clk_in);
            if (i < eff - 1) begin
                exp_rdy = s || (p && i == 0);
                check("ready", ready_out, exp_rdy);
                for (int k = 0; k < 500 && ready_out !== 1'b1; k++)
                    @(negedge core_clk_in);
                if (!exp_rdy) check("meas", meas_d, i + 1);
                // No trigger follows: judgment must fail about one limit later
                if (mode == 1) begin
                    for (waited = 0; waited < 100 && judge_ng_out !== 1'b1;
                         waited++) @(negedge core_clk_in);
                    in_win = (waited >= SIM_SEC - 2) && (waited <= SIM_SEC + 2);
                    check("wait limit", in_win, 1);
                end
            end
        end
        for (int k = 0; k < 3000 && busy_out !== 1'b0; k++)
            @(negedge core_clk_in);
        repeat (2) @(negedge core_clk_in);
        check("busy end", busy_out, 0);
        check("judge", judge_ng_out, mode == 1);
        check("ready end", ready_out, 1);
        check("captures", caps, (mode == 1) ? 1 : eff);
        check("measured", meas_d, caps);
        check("setups", setups, s ? 0 : caps);
        check("display", disp, 1);
        check("calc order", calc_at > last_md, 1);
        check("meas queue", 8'(pend_q.size()), 8'h00);
        $display("test done shared %0d parallel %0d count %0d mode %0d",
                 s, p, n, mode);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {shared_settings_in, parallel_meas_in} = 2'b00;
        task_count_in = 4'h1;
        timeout_sec_in = 6'h0a;
        lat = 4'h3;
        repeat (16) @(negedge core_clk_in);
        nrst_in = 1'b1;
        for (int m = 0; m < 8; m++) run_seq(m[0], m[1], (m < 4) ? 2 : 3, 0);
        run_seq(1, 0, 2, 1);
        run_seq(1, 1, 0, 2);
        run_seq(0, 0, 3, 0);
        print_verdict();
    end
    initial begin
        #2000000;
        errors++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule // capture_seq_test

bind capture_seq capture_seq_monitor #(.TASK_W(TASK_W)) i_mon (.*);
